/* inc/baud_if.sv */
// carrier between the receiver and its baud-rate generator
`timescale 1ns/1ps
interface baud_if;
    logic [uart_listen_pkg::PRS_W-1:0] prescale_field;
    logic [uart_listen_pkg::DIV_W-1:0] div;
    logic                              run;
    logic                              restart;
    logic                              half;

    modport gen  (input prescale_field, input div, input run, input restart, output half);
    modport user (output prescale_field, output div, output run, output restart, input half);
endinterface

/* inc/stream_if.sv */
// carrier for received characters into the receive buffer
`timescale 1ns/1ps
interface stream_if;
    logic                               valid;
    logic                               ready;
    logic [uart_listen_pkg::DATA_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* inc/uart_listen_pkg.sv */
// constants and types shared by the low-power listening receiver
package uart_listen_pkg;
    localparam int DATA_W   = 9;
    localparam int DIV_W    = 7;
    localparam int PRS_W    = 4;
    localparam int PRE_W    = 15;
    localparam int GAP_W    = 16;
    localparam int BITCNT_W = 4;
    localparam int SYNC_W   = 3;

    // frame data lengths
    localparam logic [BITCNT_W-1:0] BITS_8 = 4'h8;
    localparam logic [BITCNT_W-1:0] BITS_9 = 4'h9;

    // receiver sequencing
    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } rx_state_t;
endpackage

/* src/baud_gen.sv */
// power-of-two prescaler and half-bit divider
`timescale 1ns/1ps
module baud_gen (
    input  wire logic i_mclk,
    input  wire logic i_nrst,
    baud_if.gen       b
);
    import uart_listen_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [DIV_W-1:0] dc;
        logic             half;
    } bg_t;

    bg_t              st_reg;
    bg_t              st_next;
    logic             tick;
    logic [PRE_W-1:0] mask;

    // operation clock enable and divider
    always_comb begin
        st_next = st_reg;
        mask = PRE_W'((GAP_W'(1) << b.prescale_field) - GAP_W'(1));
        tick = b.run && ((st_reg.pre & mask) == mask);
        st_next.pre = (b.restart || !b.run) ? '0 : st_reg.pre + PRE_W'(1);
        st_next.half = 1'b0;
        if (b.restart) begin
            st_next.dc = '0;
        end else if (tick) begin
            if (st_reg.dc == b.div) begin
                st_next.dc = '0;
                st_next.half = 1'b1;
            end else begin
                st_next.dc = st_reg.dc + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign b.half = st_reg.half;

    // helper counts for the checks below
    logic [GAP_W-1:0] gap;
    logic [DIV_W:0]   nticks;
    logic             seen_t;
    logic             seen_h;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            gap <= '0;
            nticks <= '0;
            seen_t <= 1'b0;
            seen_h <= 1'b0;
        end else begin
            gap <= (tick || b.restart || !b.run) ? GAP_W'(1) : gap + GAP_W'(1);
            seen_t <= (b.restart || !b.run) ? 1'b0 : (tick ? 1'b1 : seen_t);
            seen_h <= (b.restart || !b.run) ? 1'b0 : (st_reg.half ? 1'b1 : seen_h);
            if (b.restart || st_reg.half) begin
                nticks <= {7'h00, tick};
            end else if (tick) begin
                nticks <= nticks + 8'h01;
            end
        end
    end

    prescale_gap_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        tick && seen_t && $stable(b.prescale_field) |-> gap == (GAP_W'(1) << b.prescale_field))
        else $error("prescaler tick spacing wrong");
    half_period_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        st_reg.half && seen_h && $stable(b.div) |-> nticks == {1'b0, b.div} + 8'h01)
        else $error("half-bit period wrong");
endmodule

/* src/rx_buf.sv */
// two-entry receive buffer with valid and ready on both sides
`timescale 1ns/1ps
module rx_buf (
    input  wire logic                               i_mclk,
    input  wire logic                               i_nrst,
    stream_if.snk                                   s,
    output logic     [uart_listen_pkg::DATA_W-1:0]  o_data,
    output logic                                    o_valid,
    input  wire logic                               i_ready
);
    import uart_listen_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] head;
        logic [DATA_W-1:0] tail;
        logic              hv;
        logic              tv;
    } buf_t;

    buf_t st_reg;
    buf_t st_next;

    // pop from head, push into first free slot
    always_comb begin
        st_next = st_reg;
        if (st_reg.hv && i_ready) begin
            st_next.head = st_reg.tail;
            st_next.hv = st_reg.tv;
            st_next.tv = 1'b0;
        end
        if (s.valid && !st_reg.tv) begin
            if (!st_next.hv) begin
                st_next.head = s.data;
                st_next.hv = 1'b1;
            end else begin
                st_next.tail = s.data;
                st_next.tv = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s.ready = !st_reg.tv;
    assign o_data  = st_reg.head;
    assign o_valid = st_reg.hv;
endmodule

/* src/uart_listen_rx.sv */
// uart receive channel with low-power listening wake and baud generator
`timescale 1ns/1ps

module uart_listen_rx (
    input  wire logic                               i_mclk,
    input  wire logic                               i_nrst,
    input  wire logic                               i_rxd,
    input  wire logic                               i_halted,
    input  wire logic                               i_wake_enable_bit,
    input  wire logic                               i_channel_start_trigger,
    input  wire logic                               i_channel_halt_trigger,
    input  wire logic                               i_error_output_control,
    input  wire logic                               i_listen_error_suppress,
    input  wire logic                               i_flag_clear,
    input  wire logic                               i_clock_source_select_bit,
    input  wire logic [uart_listen_pkg::PRS_W-1:0]  i_prs_low,
    input  wire logic [uart_listen_pkg::PRS_W-1:0]  i_prs_high,
    input  wire logic [uart_listen_pkg::DIV_W-1:0]  i_divider,
    input  wire logic                               i_nine_bit,
    input  wire logic                               i_parity_en,
    input  wire logic                               i_parity_odd,
    input  wire logic                               i_data_ready,
    output logic      [uart_listen_pkg::DATA_W-1:0] o_data,
    output logic                                    o_data_valid,
    output logic                                    o_channel_enabled_status,
    output logic                                    o_transfer_busy_flag,
    output logic                                    o_parity_error_flag,
    output logic                                    o_framing_error_flag,
    output logic                                    o_overrun_error_flag,
    output logic                                    o_transfer_end_interrupt,
    output logic                                    o_receive_error_interrupt,
    output logic                                    o_listen_mode,
    output logic                                    o_clock_request
);
    import uart_listen_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0]   sync;
        logic                rx;
        rx_state_t           state;
        logic                phase;
        logic [BITCNT_W-1:0] bitcnt;
        logic [DATA_W-1:0]   shreg;
        logic                par;
        logic                perr;
        logic                restart;
        logic                enabled;
        logic                busy;
        logic                listen;
        logic                clk_req;
        logic                pef;
        logic                fef;
        logic                ovf;
        logic                end_irq;
        logic                err_irq;
        logic                push;
        logic [DATA_W-1:0]   pdata;
    } rx_t;

    rx_t                 st_reg;
    rx_t                 st_next;
    logic                fall;
    logic                active;
    logic                half;
    logic                end_evt;
    logic                pe;
    logic                fe;
    logic                ov;
    logic                any_err;
    logic [BITCNT_W-1:0] nbits;
    logic [DATA_W-1:0]   frame;

    baud_if   ub ();
    stream_if us ();

    // sampling runs while awake or while the clock is requested
    assign active = !i_halted || st_reg.clk_req;
    assign half   = ub.half && active;
    assign nbits  = i_nine_bit ? BITS_9 : BITS_8;
    // qualified falling edge once the two late stages agree
    assign fall   = st_reg.rx && (st_reg.sync[2] == st_reg.sync[1]) && !st_reg.sync[2];

    assign ub.prescale_field     = i_clock_source_select_bit ? i_prs_high : i_prs_low;
    assign ub.div     = i_divider;
    assign ub.run     = active && (st_reg.state != RX_IDLE);
    assign ub.restart = st_reg.restart;
    assign us.valid   = st_reg.push;
    assign us.data    = st_reg.pdata;

    // receiver, wake and flag logic
    always_comb begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[1:0], i_rxd};
        if (st_reg.sync[2] == st_reg.sync[1]) begin
            st_next.rx = st_reg.sync[2];
        end
        st_next.restart = 1'b0;
        st_next.end_irq = 1'b0;
        st_next.err_irq = 1'b0;
        st_next.push = 1'b0;
        st_next.pef = st_reg.pef && !i_flag_clear;
        st_next.fef = st_reg.fef && !i_flag_clear;
        st_next.ovf = st_reg.ovf && !i_flag_clear;
        end_evt = 1'b0;
        frame = i_nine_bit ? st_reg.shreg : {1'b0, st_reg.shreg[DATA_W-1:1]};
        pe = st_reg.perr;
        fe = !st_reg.rx;
        ov = !us.ready;
        any_err = pe || fe || ov;
        if (i_channel_start_trigger) begin
            st_next.enabled = 1'b1;
        end
        if (!st_reg.enabled || !i_wake_enable_bit) begin
            st_next.clk_req = 1'b0;
            st_next.listen = 1'b0;
        end
        case (st_reg.state)
            RX_IDLE: begin
                if (fall && st_reg.enabled) begin
                    if (!i_halted) begin
                        st_next.state = RX_START;
                    end else if (i_wake_enable_bit) begin
                        st_next.listen = 1'b1;
                        st_next.clk_req = 1'b1;
                        st_next.state = RX_START;
                    end
                    st_next.restart = (st_next.state == RX_START);
                    st_next.phase = 1'b0;
                    st_next.bitcnt = '0;
                    st_next.par = 1'b0;
                    st_next.perr = 1'b0;
                end
            end
            RX_START: begin
                // short pulse drops back to idle
                if (half) begin
                    st_next.state = st_reg.rx ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (half) begin
                    st_next.phase = !st_reg.phase;
                    if (st_reg.phase) begin
                        st_next.shreg = {st_reg.rx, st_reg.shreg[DATA_W-1:1]};
                        st_next.par = st_reg.par ^ st_reg.rx;
                        st_next.bitcnt = st_reg.bitcnt + BITCNT_W'(1);
                        if (st_next.bitcnt == nbits) begin
                            st_next.state = i_parity_en ? RX_PARITY : RX_STOP;
                        end
                    end
                end
            end
            RX_PARITY: begin
                if (half) begin
                    st_next.phase = !st_reg.phase;
                    if (st_reg.phase) begin
                        st_next.perr = st_reg.par ^ st_reg.rx ^ i_parity_odd;
                        st_next.state = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (half) begin
                    st_next.phase = !st_reg.phase;
                    if (st_reg.phase) begin
                        end_evt = 1'b1;
                        st_next.state = RX_IDLE;
                    end
                end
            end
            default: begin
                st_next.state = RX_IDLE;
            end
        endcase
        if (end_evt) begin
            st_next.pdata = frame;
            st_next.push = us.ready;
            if (!i_listen_error_suppress) begin
                st_next.pef = st_next.pef || pe;
                st_next.fef = st_next.fef || fe;
                st_next.ovf = st_next.ovf || ov;
            end
            // error irq gated by both bits
            st_next.err_irq = any_err && i_error_output_control && !i_listen_error_suppress;
            // end irq whenever no error irq
            st_next.end_irq = !st_next.err_irq;
            st_next.listen = 1'b0;
        end
        if (i_channel_halt_trigger) begin
            st_next.enabled = 1'b0;
            st_next.state = RX_IDLE;
            st_next.clk_req = 1'b0;
            st_next.listen = 1'b0;
        end
        st_next.busy = (st_next.state != RX_IDLE);
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
            st_reg.sync <= '1;
            st_reg.rx <= 1'b1;
            st_reg.state <= RX_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    baud_gen u_baud (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .b      (ub)
    );

    rx_buf u_buf (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .s       (us),
        .o_data  (o_data),
        .o_valid (o_data_valid),
        .i_ready (i_data_ready)
    );

    assign o_channel_enabled_status  = st_reg.enabled;
    assign o_transfer_busy_flag      = st_reg.busy;
    assign o_parity_error_flag       = st_reg.pef;
    assign o_framing_error_flag      = st_reg.fef;
    assign o_overrun_error_flag      = st_reg.ovf;
    assign o_transfer_end_interrupt  = st_reg.end_irq;
    assign o_receive_error_interrupt = st_reg.err_irq;
    assign o_listen_mode             = st_reg.listen;
    assign o_clock_request           = st_reg.clk_req;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    sequence wake_edge_s;
        st_reg.state == RX_IDLE && fall && st_reg.enabled && i_halted
            && i_wake_enable_bit && !i_channel_halt_trigger;
    endsequence
    sequence err_end_s;
        end_evt && any_err && i_error_output_control && !i_listen_error_suppress;
    endsequence

    eoc_off_quiet_a: assert property (o_receive_error_interrupt |->
        $past(i_error_output_control)) else $error("error irq with eoc low");
    eoc_off_end_a: assert property (end_evt && !i_error_output_control
        |=> o_transfer_end_interrupt) else $error("missing end irq");
    err_irq_on_a: assert property (err_end_s |=> o_receive_error_interrupt)
        else $error("missing error irq");
    suppress_irq_a: assert property (o_receive_error_interrupt |->
        !$past(i_listen_error_suppress)) else $error("error irq while suppressed");
    flags_hold_a: assert property (i_listen_error_suppress && !i_flag_clear
        |=> $stable({o_parity_error_flag, o_framing_error_flag, o_overrun_error_flag}))
        else $error("flag changed while suppressed");
    wake_listen_a: assert property (wake_edge_s |=> o_listen_mode && o_clock_request
        && st_reg.state == RX_START ##1 st_reg.restart == 1'b0)
        else $error("edge did not wake");
    leave_listen_a: assert property (end_evt && !i_channel_halt_trigger
        |=> !o_listen_mode && (o_transfer_end_interrupt || o_receive_error_interrupt))
        else $error("listening not left");
    char_width_a: assert property (st_reg.push && !$past(i_nine_bit)
        |-> st_reg.pdata[DATA_W-1] == 1'b0) else $error("8-bit char has bit 8");
    short_pulse_a: assert property (st_reg.state == RX_START && half && st_reg.rx
        && !i_channel_halt_trigger |=> st_reg.state == RX_IDLE && !o_transfer_end_interrupt)
        else $error("short pulse started a frame");
    clk_req_hold_a: assert property (o_clock_request && i_wake_enable_bit
        && !i_channel_halt_trigger && o_channel_enabled_status |=> o_clock_request)
        else $error("clock request dropped");
endmodule

/* test/serial_tx_model.sv */
// behavioural remote transmitter driving the receive line
`timescale 1ns/1ps
module serial_tx_model #(
    parameter int BIT_CYC = 32
) (
    input  wire logic i_mclk,
    output logic      o_line
);
    // line idles high between frames
    initial o_line = 1'b1;

    // hold one level for a number of clock cycles
    task automatic hold(input logic lvl, input int n);
        o_line <= lvl;
        repeat (n) @(posedge i_mclk);
    endtask

    // fixed bit rate
    // whole frame: start, data lsb first, optional parity, stop
    task automatic send(input logic [8:0] d, input logic nine, input logic par_en,
                        input logic odd, input logic bad_par, input logic bad_stop);
        logic [8:0] m;
        m = nine ? d : {1'b0, d[7:0]};
        @(posedge i_mclk);
        hold(1'b0, BIT_CYC);
        for (int i = 0; i < (nine ? 9 : 8); i++) hold(m[i], BIT_CYC);
        if (par_en) hold(^m ^ odd ^ bad_par, BIT_CYC);
        hold(~bad_stop, BIT_CYC);
        o_line <= 1'b1;
    endtask
endmodule

/* test/tb_uart_listen_rx.sv */
// self-checking bench for the listening uart receiver
`timescale 1ns/1ps
module tb_uart_listen_rx;
    import uart_listen_pkg::*;
    localparam int HALF_CYC = 16;
    localparam int LIMIT    = 20000;
    logic              i_mclk, i_nrst, i_rxd, i_halted, i_wake_enable_bit;
    logic              i_channel_start_trigger, i_channel_halt_trigger, i_flag_clear;
    logic              i_error_output_control, i_listen_error_suppress;
    logic              i_clock_source_select_bit, i_nine_bit, i_parity_en, i_parity_odd;
    logic              i_data_ready;
    logic [PRS_W-1:0]  i_prs_low, i_prs_high;
    logic [DIV_W-1:0]  i_divider;
    logic [DATA_W-1:0] o_data;
    logic              o_data_valid, o_channel_enabled_status, o_transfer_busy_flag;
    logic              o_parity_error_flag, o_framing_error_flag, o_overrun_error_flag;
    logic              o_transfer_end_interrupt, o_receive_error_interrupt;
    logic              o_listen_mode, o_clock_request, listen_seen, busy_seen;
    int                fail_count, check_count, end_cnt, err_cnt, cycles, e0;

    uart_listen_rx u_uart_listen_rx (.i_mclk, .i_nrst, .i_rxd, .i_halted, .i_wake_enable_bit,
        .i_channel_start_trigger, .i_channel_halt_trigger, .i_error_output_control,
        .i_listen_error_suppress, .i_flag_clear, .i_clock_source_select_bit, .i_prs_low,
        .i_prs_high, .i_divider, .i_nine_bit, .i_parity_en, .i_parity_odd, .i_data_ready,
        .o_data, .o_data_valid, .o_channel_enabled_status, .o_transfer_busy_flag,
        .o_parity_error_flag, .o_framing_error_flag, .o_overrun_error_flag,
        .o_transfer_end_interrupt, .o_receive_error_interrupt, .o_listen_mode,
        .o_clock_request);

    serial_tx_model #(.BIT_CYC(2 * HALF_CYC)) u_serial_tx_model (.i_mclk, .o_line(i_rxd));

    // 50 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // pulse counters, listening witness and run ceiling
    always @(posedge i_mclk) begin
        cycles++;
        if (o_transfer_end_interrupt === 1'b1) end_cnt++;
        if (o_receive_error_interrupt === 1'b1) err_cnt++;
        if (o_listen_mode === 1'b1) listen_seen = 1'b1;
        if (o_transfer_busy_flag === 1'b1) busy_seen = 1'b1;
        if (cycles == LIMIT) begin
            fail_count++;
            wrap_up();
        end
    end

    // compare and count
    task automatic check(input string nm, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        check(nm, {8'h00, exp}, {8'h00, got});
    endtask

    // one-cycle trigger: 0 start, 1 halt, 2 flag clear
    task automatic trig(input int w);
        @(posedge i_mclk);
        i_channel_start_trigger <= (w == 0);
        i_channel_halt_trigger  <= (w == 1);
        i_flag_clear            <= (w == 2);
        @(posedge i_mclk);
        {i_channel_start_trigger, i_channel_halt_trigger, i_flag_clear} <= 3'h0;
        @(negedge i_mclk);
        @(negedge i_mclk);
    endtask

    // send one frame and count the interrupt pulses it caused
    task automatic frame(input logic [8:0] d, input logic bp, input logic bs,
                         input int e_end, input int e_err);
        int r0;
        e0 = end_cnt;
        r0 = err_cnt;
        {listen_seen, busy_seen} = 2'h0;
        u_serial_tx_model.send(d, i_nine_bit, i_parity_en, i_parity_odd, bp, bs);
        repeat (HALF_CYC) @(posedge i_mclk);
        @(negedge i_mclk);
        check("end_irq", 9'(e_end), 9'(end_cnt - e0));
        check("err_irq", 9'(e_err), 9'(err_cnt - r0));
    endtask

    // take the buffer head through the reader handshake
    task automatic read_char(input logic [8:0] exp);
        for (int n = 0; n < 50 && o_data_valid !== 1'b1; n++) @(negedge i_mclk);
        check("data", exp, o_data);
        @(posedge i_mclk);
        i_data_ready <= 1'b1;
        @(posedge i_mclk);
        i_data_ready <= 1'b0;
        @(negedge i_mclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        {i_nrst, i_halted, i_wake_enable_bit, i_channel_start_trigger} = 4'h0;
        {i_channel_halt_trigger, i_flag_clear, i_error_output_control} = 3'h0;
        {i_listen_error_suppress, i_clock_source_select_bit, i_nine_bit} = 3'h0;
        {i_parity_en, i_parity_odd, i_data_ready} = 3'h0;
        i_prs_low = 4'h1;
        i_prs_high = 4'h2;
        i_divider = 7'h07;
        repeat (6) @(posedge i_mclk);
        i_nrst <= 1'b1;
        trig(0);
        chk1("enabled", 1'b1, o_channel_enabled_status);
        frame(9'h0a5, 1'b0, 1'b0, 1, 0);
        chk1("busy_seen", 1'b1, busy_seen);
        read_char(9'h0a5);
        $display("test plain frame done");
        trig(1);
        @(posedge i_mclk);
        i_clock_source_select_bit <= 1'b1;
        i_divider <= 7'h03;
        {i_nine_bit, i_parity_en, i_parity_odd} <= 3'h7;
        trig(0);
        frame(9'h1c3, 1'b0, 1'b0, 1, 0);
        read_char(9'h1c3);
        $display("test nine bit frame done");
        for (int j = 0; j < 6; j++) begin
            @(posedge i_mclk);
            i_error_output_control <= (j % 3 != 0);
            i_listen_error_suppress <= (j % 3 == 2);
            i_parity_odd <= j[0];
            trig(2);
            frame(9'h05a, j >= 3, j < 3, int'(j % 3 != 1), int'(j % 3 == 1));
            chk1("parity_flag", j >= 3 && j % 3 != 2, o_parity_error_flag);
            chk1("framing_flag", j < 3 && j % 3 != 2, o_framing_error_flag);
            read_char(9'h05a);
        end
        $display("test error matrix done");
        @(posedge i_mclk);
        {i_error_output_control, i_listen_error_suppress} <= 2'h0;
        {i_clock_source_select_bit, i_nine_bit, i_parity_en, i_parity_odd} <= 4'h0;
        i_divider <= 7'h07;
        trig(1);
        chk1("busy", 1'b0, o_transfer_busy_flag);
        trig(2);
        i_wake_enable_bit <= 1'b1;
        trig(0);
        i_halted <= 1'b1;
        chk1("listen_idle", 1'b0, o_listen_mode);
        frame(9'h03c, 1'b0, 1'b0, 1, 0);
        chk1("listen_seen", 1'b1, listen_seen);
        chk1("listen_end", 1'b0, o_listen_mode);
        chk1("clock_req", 1'b1, o_clock_request);
        i_halted <= 1'b0;
        read_char(9'h03c);
        trig(1);
        chk1("clock_drop", 1'b0, o_clock_request);
        i_wake_enable_bit <= 1'b0;
        trig(0);
        i_halted <= 1'b1;
        frame(9'h0f0, 1'b0, 1'b0, 0, 0);
        $display("test listening wake done");
        i_wake_enable_bit <= 1'b1;
        e0 = end_cnt;
        u_serial_tx_model.hold(1'b0, 8);
        u_serial_tx_model.hold(1'b1, 4 * HALF_CYC);
        @(negedge i_mclk);
        check("short_irq", 9'h000, 9'(end_cnt - e0));
        chk1("short_listen", 1'b1, o_listen_mode);
        trig(1);
        chk1("halt_listen", 1'b0, o_listen_mode);
        i_halted <= 1'b0;
        i_wake_enable_bit <= 1'b0;
        $display("test short pulse done");
        trig(0);
        frame(9'h011, 1'b0, 1'b0, 1, 0);
        frame(9'h022, 1'b0, 1'b0, 1, 0);
        frame(9'h033, 1'b0, 1'b0, 1, 0);
        chk1("overrun_flag", 1'b1, o_overrun_error_flag);
        read_char(9'h011);
        read_char(9'h022);
        chk1("drained", 1'b0, o_data_valid);
        $display("test buffer stall done");
        wrap_up();
    end
endmodule
